//--- rtl/pin_mux_pkg.sv
package pin_mux_pkg;
    localparam int NUM_PORTS = 10;
    localparam int PINS_PER_PORT = 8;
    localparam int NUM_PINS = NUM_PORTS * PINS_PER_PORT;
    localparam int SEL_W = 3;
    typedef enum logic [2:0] {
        FN_INPUT,
        FN_ALT_IN1,
        FN_ALT_OUT1,
        FN_ALT_OUT2,
        FN_ALT_OUT3
    } pin_fn_t;
    localparam logic [2:0] FN_RESET = 3'h0;
    localparam logic STROBE_MODE_RESET = 1'b0;
endpackage : pin_mux_pkg

//--- rtl/pin_cell.sv
`timescale 1ns/1ps
module pin_cell
    import pin_mux_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pin_in,
    input wire pin_fn_t fn,
    input wire logic out1,
    input wire logic out2,
    input wire logic out3,
    output logic pin_out,
    output logic pin_oe_n,
    output logic level,
    output logic alt_in_route
);
    import pin_mux_pkg::*;
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    logic out_q;
    logic out_d;
    logic oe_n_q;
    logic oe_n_d;

    always_comb begin
        meta_d = pin_in;
        sync_d = meta_q;
        out_d = 1'b0;
        oe_n_d = 1'b1;
        unique case (fn)
            FN_ALT_OUT1: begin
                out_d = out1;
                oe_n_d = 1'b0;
            end
            FN_ALT_OUT2: begin
                out_d = out2;
                oe_n_d = 1'b0;
            end
            FN_ALT_OUT3: begin
                out_d = out3;
                oe_n_d = 1'b0;
            end
            default: begin
                out_d = 1'b0;
                oe_n_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            out_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            out_q <= out_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign pin_out = out_q;
    assign pin_oe_n = oe_n_q;
    assign level = sync_q;
    assign alt_in_route = (fn == FN_ALT_IN1);
endmodule : pin_cell

//--- rtl/port_pin_function_mux.sv
`timescale 1ns/1ps
// Behaviour
// - pins reset to high-impedance inputs
// - reset pins read as general inputs
// - default peripheral inputs fed from reset
// - pin level readable as input in every function; reads 0 while in reset
// - per pin select alt input or outputs
// - write strobes may become byte selects
module port_pin_function_mux
    import pin_mux_pkg::*;
#(
    parameter int PINS = NUM_PINS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe_n,
    input wire logic [PINS*SEL_W-1:0] pin_fn_sel,
    input wire logic [PINS-1:0] default_in_en,
    input wire logic [PINS-1:0] alt_out1,
    input wire logic [PINS-1:0] alt_out2,
    input wire logic [PINS-1:0] alt_out3,
    output logic [PINS-1:0] gpio_in,
    output logic [PINS-1:0] default_in,
    output logic [PINS-1:0] alt_in1,
    input wire logic byte_select_mode,
    input wire logic ext_write_low_n,
    input wire logic ext_write_high_n,
    input wire logic ext_lb_sel_n,
    input wire logic ext_ub_sel_n,
    output logic ext_low_byte_write_strobe,
    output logic ext_high_byte_write_strobe
);
    import pin_mux_pkg::*;
    logic [PINS-1:0] level;
    logic [PINS-1:0] alt_route;
    logic [PINS-1:0] any_alt_q;
    logic [PINS-1:0] any_alt_d;
    logic mode_d;
    logic low_q;
    logic low_d;
    logic high_q;
    logic high_d;

    function automatic pin_fn_t decode_fn(input logic [SEL_W-1:0] code);
        pin_fn_t f;
        f = FN_INPUT;
        if (code <= 3'h4) begin
            f = pin_fn_t'(code);
        end
        return f;
    endfunction : decode_fn

    ////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        pin_cell u_cell (
            .sys_clk(sys_clk),
            .rst(rst),
            .pin_in(pin_in[i]),
            .fn(decode_fn(pin_fn_sel[i*SEL_W +: SEL_W])),
            .out1(alt_out1[i]),
            .out2(alt_out2[i]),
            .out3(alt_out3[i]),
            .pin_out(pin_out[i]),
            .pin_oe_n(pin_oe_n[i]),
            .level(level[i]),
            .alt_in_route(alt_route[i])
        );
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            any_alt_d[i] = (pin_fn_sel[i*SEL_W +: SEL_W] != FN_RESET);
        end
        mode_d = byte_select_mode;
        low_d = mode_d ? ext_lb_sel_n : ext_write_low_n;
        high_d = mode_d ? ext_ub_sel_n : ext_write_high_n;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            any_alt_q <= '0;
            low_q <= 1'b1;
            high_q <= 1'b1;
        end else begin
            any_alt_q <= any_alt_d;
            low_q <= low_d;
            high_q <= high_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    assign gpio_in = level;
    assign default_in = level & default_in_en & ~any_alt_q;
    assign alt_in1 = level & alt_route;
    assign ext_low_byte_write_strobe = low_q;
    assign ext_high_byte_write_strobe = high_q;
endmodule : port_pin_function_mux

//--- bench/pin_partner.sv
`timescale 1ns/1ps
module pin_partner #(parameter int N = 4) (
    input wire logic [N-1:0] pin_out,
    input wire logic [N-1:0] pin_oe_n,
    input wire logic [N-1:0] drv,
    output logic [N-1:0] level
);
    // off-chip side drives only where the device has its driver off
    assign level = (pin_oe_n & drv) | (~pin_oe_n & pin_out);
endmodule : pin_partner

//--- bench/pin_mux_props.sv
`timescale 1ns/1ps
module pin_mux_props
    import pin_mux_pkg::*;
#(parameter int PINS = 4) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [PINS-1:0] pin_in,
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe_n,
    input wire logic [PINS*SEL_W-1:0] pin_fn_sel,
    input wire logic [PINS-1:0] default_in_en,
    input wire logic [PINS-1:0] alt_out2,
    input wire logic [PINS-1:0] gpio_in,
    input wire logic [PINS-1:0] default_in,
    input wire logic [PINS-1:0] alt_in1,
    input wire logic byte_select_mode,
    input wire logic ext_write_low_n,
    input wire logic ext_lb_sel_n,
    input wire logic ext_low_byte_write_strobe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_RST_HIZ: assert property (disable iff (1'b0) rst |-> &pin_oe_n) else $error("pins driven in reset");
    AST_IN_HIZ: assert property (!$past(rst) && $past(pin_fn_sel[2:0]) <= 3'h1 |-> pin_oe_n[0])
        else $error("input pin driven");
    AST_GPIO: assert property (!$past(rst) && !$past(rst, 2) |-> gpio_in == $past(pin_in, 2))
        else $error("gpio input wrong");
    AST_DEF_IN: assert property (!$past(rst) && $past(pin_fn_sel[2:0]) == 3'h0
        |-> default_in[0] == (gpio_in[0] & default_in_en[0])) else $error("default input wrong");
    AST_ALT_IN: assert property (pin_fn_sel[2:0] == 3'h1 |-> alt_in1[0] == gpio_in[0])
        else $error("alt input wrong");
    AST_OUT2: assert property (!$past(rst) && $past(pin_fn_sel[2:0]) == 3'h3 |-> pin_out[0] == $past(alt_out2[0]))
        else $error("alt out2 wrong");
    AST_OE: assert property (!$past(rst) |-> pin_oe_n[0] == !($past(pin_fn_sel[2:0]) inside {3'h2, 3'h3, 3'h4}))
        else $error("enable wrong");
    AST_STROBE: assert property (!$past(rst) |-> ext_low_byte_write_strobe ==
        ($past(byte_select_mode) ? $past(ext_lb_sel_n) : $past(ext_write_low_n))) else $error("strobe wrong");
    cover property (pin_fn_sel[2:0] == 3'h4);
    cover property (byte_select_mode);
    cover property (pin_fn_sel[2:0] == 3'h1);
endmodule : pin_mux_props
bind port_pin_function_mux pin_mux_props #(.PINS(PINS)) u_props (.*);

//--- bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
    import pin_mux_pkg::*;
    logic sys_clk = 0, rst, bsm = 0, wl = 1, wh = 1, lb = 0, ub = 0, sl, sh;
    logic [3:0] lvl, po, oe, drv = 4'h5, en = 4'h3, a1 = 0, a2 = 0, a3 = 0, gi, di, ai;
    logic [11:0] sel = 0;
    int num_errors = 0, total_checks = 0, cyc = 0;
    always #5 sys_clk = ~sys_clk;
    pin_partner #(.N(4)) far (.pin_out(po), .pin_oe_n(oe), .drv(drv), .level(lvl));
    port_pin_function_mux #(.PINS(4)) dut (.sys_clk(sys_clk), .rst(rst), .pin_in(lvl), .pin_out(po), .pin_oe_n(oe),
        .pin_fn_sel(sel), .default_in_en(en), .alt_out1(a1), .alt_out2(a2), .alt_out3(a3), .gpio_in(gi),
        .default_in(di), .alt_in1(ai), .byte_select_mode(bsm), .ext_write_low_n(wl), .ext_write_high_n(wh),
        .ext_lb_sel_n(lb), .ext_ub_sel_n(ub), .ext_low_byte_write_strobe(sl), .ext_high_byte_write_strobe(sh));
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wt
    task automatic t_inputs;
        `CHK("oe_rst", 4'hF, oe)
        @(posedge sys_clk);
        rst <= 1'b0;
        wt(4);
        `CHK("gpio", 4'h5, gi)
        `CHK("def_in", 4'h1, di)
        `CHK("oe_idle", 4'hF, oe)
    endtask : t_inputs
    task automatic t_outputs;
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            sel <= {9'h0, 3'(k + 2)};
            a1 <= {4{k == 0}};
            a2 <= {4{k == 1}};
            a3 <= {4{k == 2}};
            drv <= 4'h0;
            wt(3);
            `CHK("out", 4'h1, po)
            `CHK("oe_out", 4'hE, oe)
            `CHK("gpio_out", 4'h1, gi)
        end
        @(posedge sys_clk);
        sel <= 12'h001;
        drv <= 4'h1;
        wt(3);
        `CHK("alt_in", 4'h1, ai)
        `CHK("oe_altin", 4'hF, oe)
    endtask : t_outputs
    task automatic t_strobe;
        @(posedge sys_clk);
        wl <= 0;
        wt(2);
        `CHK("strobe", 2'h2, {sh, sl})
        @(posedge sys_clk);
        bsm <= 1;
        lb <= 1;
        wt(2);
        `CHK("bytesel", 2'h1, {sh, sl})
    endtask : t_strobe
    task automatic end_sim;
        if (num_errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        rst <= 1'b1;
        wt(1);
        t_inputs();
        t_outputs();
        t_strobe();
        end_sim();
    end
endmodule : tb_top
